// ---- verilog/icrr_pkg.sv ----
// Constants and carrier types for the two-wire register read port
package icrr_pkg;

   // ----------------------------------------------------------------
   // Protocol constants
   // ----------------------------------------------------------------
   localparam logic [6:0] SLV_ADDR_BASE = 7'h68;
   localparam logic [2:0] OPC_READ      = 3'h4;
   localparam logic [2:0] NUM_CMD       = 3'h4;
   localparam logic [3:0] BITS_BYTE     = 4'h8;
   localparam logic [1:0] FIRST_TX_IDX  = 2'h3;
   localparam logic [1:0] ALIGN_ZERO    = 2'h0;
   localparam logic [31:0] HELD_RESET   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX   = 3'h1,
      ST_RACK = 3'h3,
      ST_TX   = 3'h2,
      ST_MACK = 3'h6
   } icrr_state_t;

   typedef struct packed {
      logic       port0;
      logic       rsvd;
      logic [3:0] be;
      logic [1:0] addr_hi;
   } icrr_cmd2_t;

   typedef struct packed {
      logic [4:0]  port;
      logic [3:0]  be;
      logic [11:0] addr;
   } icrr_req_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } icrr_ev_t;

endpackage

// ---- verilog/icrr_pin_sync.sv ----
// Pin synchronisers and bus condition detection for the two-wire port
`timescale 1ns/1ps
module icrr_pin_sync import icrr_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [2:0] strap_i,
   output icrr_ev_t        ev_o,
   output logic [2:0]      strap_o
);

   logic [4:0] meta;
   logic [4:0] stage;
   logic       scl_d;
   logic       sda_d;

   // ----------------------------------------------------------------
   // Two flops per pin, plus a delay flop on SCL and SDA for edge detection; the first stage never feeds logic
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta  <= 5'h03;
         stage <= 5'h03;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         meta  <= {strap_i, scl_i, sda_i};
         stage <= meta;
         scl_d <= stage[1];
         sda_d <= stage[0];
      end
   end

   assign strap_o     = stage[4:2];
   assign ev_o.scl    = stage[1];
   assign ev_o.sda    = stage[0];
   assign ev_o.start  = stage[1] && scl_d && sda_d && !stage[0];
   assign ev_o.stop   = stage[1] && scl_d && !sda_d && stage[0];
   assign ev_o.rise   = stage[1] && !scl_d;
   assign ev_o.fall   = !stage[1] && scl_d;

endmodule // icrr_pin_sync

// ---- verilog/icrr_top.sv ----
// Two-wire slave that takes a read command and returns a 32-bit register
//
// Behaviour
// [R1] Answer slave address 68h; D0h opens the write command packet.
// [R2] Exactly four command bytes follow, each acknowledged; a fifth is refused.
// [R3] Command byte 0 low bits 100b request a register read.
// [R4] Command byte 2 bits 5:2 carry the four byte enables.
// [R5] Command byte 2 bits 1:0 carry register address bits 11:10.
// [R6] Command byte 3 carries register address bits 9:2.
// [R7] Repeated start with D1h opens the read data packet.
// [R8] Register bytes go out most significant first, byte 0 last.
// [R9] Master acks each byte but the last, then sends stop.
// [R10] Command byte 1 low nibble and byte 2 bit 7 form port index.
// [R11] Register address bits 1:0 are always zero.
// [R12] Byte enable bits 2..5 select register byte lanes 0..3.
// [R13] Three straps replace the low slave address bits; zero gives 68h.
// [R14] Captured value stays stable through the read; foreign traffic ignored.
`timescale 1ns/1ps
module icrr_top import icrr_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic [2:0]  strap_i,
   input  wire logic [31:0] reg_rdata_i,
   input  wire logic        reg_rvalid_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic             reg_req_o,
   output icrr_req_t        req_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = be[i] ? d[8*i +: 8] : 8'h00;
      end
      return m;
   endfunction

   function automatic logic [7:0] pick_byte(input logic [31:0] d, input logic [1:0] idx);
      return d[8*idx +: 8];
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   icrr_ev_t    ev;
   logic [2:0]  strap;
   icrr_state_t st;
   logic [7:0]  sh;
   logic [7:0]  tx_sh;
   logic [3:0]  bitcnt;
   logic        first;
   logic        rd;
   logic        last;
   logic [2:0]  cmd_idx;
   logic [1:0]  tx_idx;
   logic [7:0]  cmd_op;
   logic [7:0]  cmd_port;
   icrr_cmd2_t  cmd2;
   logic [7:0]  cmd_addr;
   logic [31:0] held;
   logic        pend;

   icrr_pin_sync u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .strap_i (strap_i),
      .ev_o    (ev),
      .strap_o (strap)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic [6:0] own_addr = {SLV_ADDR_BASE[6:3], strap};       // see [R13]
   wire logic       byte_end = (st == ST_RX) && ev.fall && (bitcnt == BITS_BYTE);
   wire logic       addr_hit = first && (sh[7:1] == own_addr);     // see [R1]
   wire logic       cmd_ok   = !first && (cmd_idx < NUM_CMD);      // see [R2]
   wire logic       give_ack = first ? addr_hit : cmd_ok;
   wire logic       go_read  = byte_end && addr_hit && sh[0];     // see [R7]
   wire logic       cmd_done = byte_end && !first && (cmd_idx == NUM_CMD - 3'h1);
   wire logic       opc_ok   = (cmd_op[2:0] == OPC_READ);          // see [R3]
   wire logic       tx_load  = (st == ST_RACK) && ev.fall && rd;
   wire logic [7:0] tx_byte  = pick_byte(held, tx_idx);           // see [R8]
   icrr_req_t       next_req;
   assign next_req.port = {cmd_port[3:0], cmd2.port0};             // see [R10]
   assign next_req.be   = cmd2.be;                                 // see [R4]
   assign next_req.addr = {cmd2.addr_hi, sh, ALIGN_ZERO};          // see [R5] see [R6] see [R11]

   // ----------------------------------------------------------------
   // Bit and byte sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st       <= ST_IDLE;
         sh       <= 8'h00;
         tx_sh    <= 8'h00;
         bitcnt   <= 4'h0;
         first    <= 1'b0;
         rd       <= 1'b0;
         last     <= 1'b0;
         cmd_idx  <= 3'h0;
         tx_idx   <= FIRST_TX_IDX;
         cmd_op   <= 8'h00;
         cmd_port <= 8'h00;
         cmd2     <= '0;
         cmd_addr <= 8'h00;
         sda_oe_o <= 1'b0;
      end else if (ev.start) begin
         st       <= ST_RX;
         bitcnt   <= 4'h0;
         first    <= 1'b1;
         sda_oe_o <= 1'b0;
      end else if (ev.stop) begin
         st       <= ST_IDLE;
         sda_oe_o <= 1'b0;
      end else begin
         unique case (st)
            ST_IDLE: begin
               sda_oe_o <= 1'b0;
            end
            ST_RX: begin
               if (ev.rise) begin
                  sh     <= {sh[6:0], ev.sda};
                  bitcnt <= bitcnt + 4'h1;
               end
               if (byte_end) begin
                  if (give_ack) begin
                     st       <= ST_RACK;
                     sda_oe_o <= 1'b1;                             // see [R2]
                     if (first) begin
                        rd      <= sh[0];
                        cmd_idx <= 3'h0;
                        tx_idx  <= FIRST_TX_IDX;
                        last    <= 1'b0;
                     end else begin
                        cmd_idx <= cmd_idx + 3'h1;
                        unique case (cmd_idx[1:0])
                           2'h0: cmd_op   <= sh;
                           2'h1: cmd_port <= sh;
                           2'h2: cmd2     <= sh;
                           2'h3: cmd_addr <= sh;
                        endcase
                     end
                  end else begin
                     // Wrong address or surplus byte: stay off the bus
                     st <= ST_IDLE;                                // see [R14]
                  end
               end
            end
            ST_RACK: begin
               if (ev.fall) begin
                  first  <= 1'b0;
                  bitcnt <= 4'h0;
                  if (rd) begin
                     st       <= ST_TX;
                     tx_sh    <= tx_byte;
                     sda_oe_o <= !tx_byte[7];
                     bitcnt   <= 4'h1;
                     tx_idx   <= tx_idx - 2'h1;                    // see [R8]
                     last     <= (tx_idx == 2'h0);
                  end else begin
                     st       <= ST_RX;
                     sda_oe_o <= 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (ev.fall) begin
                  if (bitcnt == BITS_BYTE) begin
                     st       <= ST_MACK;
                     sda_oe_o <= 1'b0;
                  end else begin
                     tx_sh    <= {tx_sh[6:0], 1'b0};
                     sda_oe_o <= !tx_sh[6];
                     bitcnt   <= bitcnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               // A not-acknowledge or the fourth byte ends the read
               if (ev.rise) begin
                  st <= (ev.sda || last) ? ST_IDLE : ST_RACK;      // see [R9]
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register request and capture
   // ----------------------------------------------------------------
   // The word is frozen once the read address is taken, so a late answer
   // from the register space cannot tear a byte already on the wire.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_req_o <= 1'b0;
         req_o     <= '0;
         pend      <= 1'b0;
         held      <= HELD_RESET;
         sda_o     <= 1'b0;
      end else begin
         reg_req_o <= cmd_done && opc_ok;                          // see [R3]
         if (cmd_done && opc_ok) begin
            req_o <= next_req;
         end
         if (cmd_done && opc_ok) begin
            pend <= 1'b1;
         end else if (go_read) begin
            pend <= 1'b0;                                          // see [R14]
         end else if (reg_rvalid_i && pend) begin
            pend <= 1'b0;
            held <= lane_mask(reg_rdata_i, req_o.be);              // see [R12]
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_addr_ack;
      @(posedge clk_i) disable iff (reset_i)
      (byte_end && addr_hit) |=> (st == ST_RACK) && sda_oe_o;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // see [R1] see [R13]

   property p_foreign;
      @(posedge clk_i) disable iff (reset_i)
      (byte_end && first && !addr_hit) |=> (st == ST_IDLE) && !sda_oe_o;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address answered"); // see [R14]

   property p_cmd_count;
      @(posedge clk_i) disable iff (reset_i)
      (byte_end && !first) |=> (sda_oe_o == ($past(cmd_idx) < NUM_CMD));
   endproperty
   a_cmd_count: assert property (p_cmd_count) else $error("command byte ack wrong"); // see [R2]

   property p_req_opc;
      @(posedge clk_i) disable iff (reset_i)
      reg_req_o |-> (cmd_op[2:0] == OPC_READ) ##1 !reg_req_o;
   endproperty
   a_req_opc: assert property (p_req_opc) else $error("request without read code"); // see [R3]

   property p_req_fields;
      @(posedge clk_i) disable iff (reset_i)
      reg_req_o |-> (req_o.port == {cmd_port[3:0], cmd2.port0}) && (req_o.be == cmd2.be)
                    && (req_o.addr[11:2] == {cmd2.addr_hi, cmd_addr});
   endproperty
   a_req_fields: assert property (p_req_fields) else $error("request fields wrong"); // see [R4] see [R5] see [R6] see [R10]

   property p_align;
      @(posedge clk_i) disable iff (reset_i)
      reg_req_o |-> (req_o.addr[1:0] == ALIGN_ZERO);
   endproperty
   a_align: assert property (p_align) else $error("address not dword aligned"); // see [R11]

   property p_mask;
      @(posedge clk_i) disable iff (reset_i)
      (reg_rvalid_i && pend && !go_read && !(cmd_done && opc_ok))
         |=> (held[31:24] == ($past(reg_rdata_i[31:24]) & {8{req_o.be[3]}}))
             && (held[23:16] == ($past(reg_rdata_i[23:16]) & {8{req_o.be[2]}}))
             && (held[15:8] == ($past(reg_rdata_i[15:8]) & {8{req_o.be[1]}}))
             && (held[7:0] == ($past(reg_rdata_i[7:0]) & {8{req_o.be[0]}}));
   endproperty
   a_mask: assert property (p_mask) else $error("byte lanes not masked"); // see [R12]

   property p_msb_first;
      @(posedge clk_i) disable iff (reset_i)
      (tx_load && tx_idx == FIRST_TX_IDX) |=> (tx_sh == held[31:24]) && (sda_oe_o == !held[31]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first byte not byte 3"); // see [R8]

   property p_stable;
      @(posedge clk_i) disable iff (reset_i)
      (rd && (st == ST_TX || st == ST_MACK)) |=> $stable(held);
   endproperty
   a_stable: assert property (p_stable) else $error("held word changed in read"); // see [R14]

endmodule // icrr_top

// ---- tb/icrr_master.sv ----
// Behavioural two-wire bus master for the register read port
`timescale 1ns/1ps
module icrr_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   // ----------------------------------------------------------------
   // Bus timing: a quarter of the 200 ns bus period is two core cycles
   // ----------------------------------------------------------------
   // The bus clock idles high and only moves inside frames
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Data changes only while SCL is low; the wire is sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      sda_oe_o = ~b;
      tick(3);
      scl_o = 1'b1;
      tick(2);
      r = sda_i;
      tick(2);
      scl_o = 1'b0;
   endtask
   task automatic start();
      tick(4);
      sda_oe_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b1;
      tick(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      tick(1);
      sda_oe_o = 1'b1;
      tick(3);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b0;
      tick(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // A released SDA reads high through the pull-up, so a NACK is a release
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule // icrr_master

// ---- tb/icrr_top_test.sv ----
// Self-checking bench for the two-wire register read port
`timescale 1ns/1ps
module icrr_top_test;
   import icrr_pkg::*;
   `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
   typedef struct packed {
      logic [4:0]  port;
      logic [3:0]  be;
      logic [11:0] addr;
      logic [31:0] word;
   } icrr_row_t;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        reg_rvalid_i = 1'b0;
   logic [2:0]  strap_i = 3'h0;
   logic [2:0]  pend = 3'h0;
   logic [31:0] word = 32'h0;
   logic [31:0] got, exp;
   logic [5:0]  acks;
   logic [7:0]  d8;
   logic        sda_o, sda_oe_o, reg_req_o, m_scl, m_oe, a;
   icrr_req_t   req_o;
   int          err_total = 0, check_count = 0, reqs = 0, cyc = 0, n;
   // The device pulls low only with its data level at zero, so a stuck data bit shows
   wire         sda = ~((sda_oe_o & ~sda_o) | m_oe);
   // Outside a valid strobe the word is inverted so stale capture shows
   wire [31:0]  reg_rdata_i = reg_rvalid_i ? word : ~word;
   icrr_row_t   rows [3] = '{{5'h00, 4'hF, 12'h0F8, 32'h0000_0000},
                            {5'h05, 4'hA, 12'hFFC, 32'hA5C3_5A3C},
                            {5'h03, 4'h5, 12'h400, 32'h1234_5678}};
   icrr_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .scl_i(m_scl), .sda_i(sda),
      .strap_i(strap_i), .reg_rdata_i(reg_rdata_i), .reg_rvalid_i(reg_rvalid_i),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_req_o(reg_req_o), .req_o(req_o));
   icrr_master i_master (.clk_i(clk_i), .sda_i(sda), .scl_o(m_scl), .sda_oe_o(m_oe));
   // ----------------------------------------------------------------
   // Clock, register space answer and hang guard
   // ----------------------------------------------------------------
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      #1;
      reg_rvalid_i = pend[2];
      pend = {pend[1:0], reg_req_o};
      reqs += int'(reg_req_o);
   end
   initial begin
      wait (cyc == 40000);
      err_total++;
      finish_test();
   end
   task automatic finish_test();
      $display("Checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wb(input logic [7:0] d);
      i_master.wbyte(d, a);
      acks = {acks[4:0], a};
   endtask
   // Four data bytes, byte 3 first, nack on the last, then stop
   task automatic rd4();
      logic [7:0] d;
      for (int i = 3; i >= 0; i--) begin
         i_master.rbyte(i == 0, d);
         got[8*i +: 8] = d;
      end
      i_master.stop();
   endtask
   // Whole read: command packet, repeated start, four data bytes, stop
   task automatic op(input logic [6:0] sa, input logic [31:0] cmd);
      i_master.start();
      wb({sa, 1'b0});
      for (int i = 3; i >= 0; i--) wb(cmd[8*i +: 8]);
      i_master.start();
      wb({sa, 1'b1});
      rd4();
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      #1 reset_i = 1'b0;
      `CHK({sda_oe_o, reg_req_o, req_o}, 23'h0)
      repeat (4) @(posedge clk_i);
      foreach (rows[k]) begin
         word = rows[k].word;
         exp = word & {{8{rows[k].be[3]}}, {8{rows[k].be[2]}},
                       {8{rows[k].be[1]}}, {8{rows[k].be[0]}}};
         op(7'h68, {8'h04, 4'h0, rows[k].port[4:1], rows[k].port[0], 1'b0,
                    rows[k].be, rows[k].addr[11:2]});
         `CHK(acks, 6'h3F)
         `CHK({req_o.port, req_o.be}, {rows[k].port, rows[k].be})
         `CHK(req_o.addr, {rows[k].addr[11:2], 2'h0})
         `CHK(got, exp)
      end
      // Foreign slave address draws no ack and no request
      n = reqs;
      op(7'h50, 32'h0400_3C3E);
      `CHK(acks, 6'h00)
      // Other opcode is acked but starts no register read
      op(7'h68, 32'h0500_3C3E);
      `CHK(acks, 6'h3F)
      `CHK(reqs, n)
      // A fifth command byte is refused
      i_master.start();
      wb(8'hD0);
      for (int i = 0; i < 5; i++) wb(8'h04);
      i_master.stop();
      `CHK(acks, 6'h3E)
      // Straps move the slave address; the old one falls silent
      strap_i = 3'h5;
      repeat (4) @(posedge clk_i);
      #1 word = 32'hC0DE_F00D;
      op(7'h6D, 32'h0400_3C3E);
      `CHK(acks, 6'h3F)
      `CHK(got, 32'hC0DE_F00D)
      op(7'h68, 32'h0400_3C3E);
      `CHK(acks, 6'h00)
      // Reset in mid-run clears the request and the held word
      reset_i = 1'b1;
      repeat (6) @(posedge clk_i);
      #1 reset_i = 1'b0;
      `CHK({sda_oe_o, reg_req_o, req_o}, 23'h0)
      repeat (4) @(posedge clk_i);
      i_master.start();
      wb(8'hDB);
      `CHK(acks[0], 1'b1)
      rd4();
      `CHK(got, HELD_RESET)
      // Master nack on the first data byte ends the read early
      i_master.start();
      wb(8'hDB);
      i_master.rbyte(1'b1, d8);
      `CHK(d8, 8'h00)
      i_master.rbyte(1'b1, d8);
      `CHK(d8, 8'hFF)
      i_master.stop();
      finish_test();
   end
endmodule // icrr_top_test
